// ==== core/dll_ctrl_end.sv ====
// controller end: clock divider, switching sequencer, axi4-lite registers
// assumes an axi4-lite master on CLK and the dram end on the link
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
module dll_ctrl_end
   import dll_switch_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // link
   dll_link_if.ctrl LINK,
   // axi4-lite write
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   typedef enum logic [3:0] {idle, dll_off_mrs, sr_entry, freq_change, sr_exit, dll_on_mrs,
      dll_reset_mrs, cl_mrs, cwl_mrs, zq_cal, lock_wait, step_wait} step_t;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] aw_addr, div_new, div_cur, div_cnt;
   logic [31:0] w_data, time_a, time_b, time_c, mr_val;
   logic [3:0] w_strb;
   logic aw_got, w_got, to_off, zq_en, odt_idle, busy, done, dll_off;
   step_t step, ret;
   logic [15:0] cnt, lock_cnt;

   wire [7:0] t_mod = time_a[7:0];
   wire [7:0] t_mrd = time_a[15:8];
   wire [7:0] t_cksre = time_a[23:16];
   wire [7:0] t_cksrx = time_a[31:24];
   wire [15:0] t_xs = time_b[15:0];
   wire [15:0] t_dllk = time_b[31:16];
   wire [15:0] t_zq = time_c[15:0];
   wire tick = LINK.ck_tick;

   // ----------------------------------------------------------------
   // axi4-lite decode
   // ----------------------------------------------------------------
   wire do_write = aw_got && w_got && !BVALID;
   wire w_ctrl = do_write && aw_addr == CTRL_OFS;
   wire w_ta = do_write && aw_addr == TIME_A_OFS;
   wire w_tb = do_write && aw_addr == TIME_B_OFS;
   wire w_tc = do_write && aw_addr == TIME_C_OFS;
   wire w_mr = do_write && aw_addr == MRVAL_OFS;
   wire w_hit = w_ctrl || w_ta || w_tb || w_tc || w_mr || (do_write && aw_addr == STATUS_OFS);
   wire strb_ok = w_strb[0];
   wire go = w_ctrl && strb_ok && w_data[GO_BIT] && !busy;
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] ctrl_rd = {16'h0000, div_new, 4'h0, odt_idle, zq_en, to_off, 1'b0};
   wire [31:0] stat_rd = {16'h0000, div_cur, 5'h00, dll_off, done, busy};
   wire ar_hit = ARADDR == CTRL_OFS || ARADDR == STATUS_OFS || ARADDR == TIME_A_OFS
      || ARADDR == TIME_B_OFS || ARADDR == TIME_C_OFS || ARADDR == MRVAL_OFS;
   wire [31:0] rd_mux = ARADDR == CTRL_OFS ? ctrl_rd : ARADDR == STATUS_OFS ? stat_rd
      : ARADDR == TIME_A_OFS ? time_a : ARADDR == TIME_B_OFS ? time_b
      : ARADDR == TIME_C_OFS ? time_c : ARADDR == MRVAL_OFS ? mr_val : 32'h0000_0000;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_addr <= AWADDR;
            aw_got <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_data <= WDATA;
            w_strb <= WSTRB;
            w_got <= 1'b1;
            WREADY <= 1'b0;
         end
         if (do_write) begin
            BVALID <= 1'b1;
            BRESP <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RDATA <= rd_mux;
         RRESP <= ar_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   // settings are frozen while a switch runs
   always_ff @(posedge CLK) begin
      if (RESET) begin
         to_off <= 1'b1;
         zq_en <= 1'b0;
         odt_idle <= 1'b0;
         div_new <= DIV_RESET;
         time_a <= {8'(T_CKSRX_CYC), 8'(T_CKSRE_CYC), 8'(T_MRD_NCK), 8'(T_MOD_NCK)};
         time_b <= {16'(T_DLLK_NCK), 16'(T_XS_CYC)};
         time_c <= {16'h0000, 16'(T_ZQOPER_NCK)};
         mr_val <= {2'h0, MR2_CWL6, 2'h0, MR0_CL6};
      end else if (!busy) begin
         if (w_ctrl && w_strb[0]) begin
            to_off <= w_data[DIR_BIT];
            zq_en <= w_data[ZQ_BIT];
            odt_idle <= w_data[ODT_BIT];
         end
         if (w_ctrl && w_strb[1] && w_data[15:8] != 8'h00) div_new <= w_data[15:8];
         if (w_ta) time_a <= (time_a & ~wmask) | (w_data & wmask);
         if (w_tb) time_b <= (time_b & ~wmask) | (w_data & wmask);
         if (w_tc) time_c <= (time_c & ~wmask) | (w_data & wmask);
         if (w_mr) mr_val <= (mr_val & ~wmask) | (w_data & wmask);
      end
   end

   // ----------------------------------------------------------------
   // dram clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         div_cnt <= 8'h00;
         LINK.ck_tick <= 1'b0;
      end else begin
         LINK.ck_tick <= div_cnt == 8'h00;
         div_cnt <= (div_cnt == 8'h00) ? div_cur - 8'h01 : div_cnt - 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // sequencer; moves only on dram edges, commands last one edge
   // ----------------------------------------------------------------
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
      {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= c;
      LINK.ba <= b;
      LINK.addr <= a;
   endtask

   task automatic hold(input logic [15:0] t, input step_t nxt);
      cnt <= (t == 16'h0000) ? 16'h0000 : t - 16'h0001;
      ret <= nxt;
      step <= step_wait;
   endtask

   always_ff @(posedge CLK) begin
      if (RESET) begin
         step <= idle;
         ret <= idle;
         cnt <= 16'h0000;
         lock_cnt <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         dll_off <= 1'b0;
         div_cur <= DIV_RESET;
         LINK.cke <= 1'b1;
         LINK.odt <= 1'b0;
         issue(CMD_NOP, 3'h0, 14'h0000);
      end else begin
         if (go) begin
            busy <= 1'b1;
            done <= 1'b0;
         end
         if (tick && lock_cnt != 16'h0000) lock_cnt <= lock_cnt - 16'h0001;
         // odt parked low for the whole switch
         LINK.odt <= busy ? 1'b0 : odt_idle;
         if (tick) begin
            issue(CMD_NOP, 3'h0, 14'h0000);
            unique case (step)
               idle: if (busy) step <= to_off ? dll_off_mrs : sr_entry;
               dll_off_mrs: begin
                  issue(CMD_MRS, MR1_SEL, MR1_DLL_OFF);
                  dll_off <= 1'b1;
                  hold({8'h00, t_mod}, sr_entry);
               end
               sr_entry: begin
                  LINK.cke <= 1'b0;
                  issue(CMD_REF, 3'h0, 14'h0000);
                  hold({8'h00, t_cksre}, freq_change);
               end
               freq_change: begin
                  div_cur <= div_new;
                  hold({8'h00, t_cksrx}, sr_exit);
               end
               sr_exit: begin
                  LINK.cke <= 1'b1;
                  // direction, not the current dll state, picks the exit path
                  hold(t_xs, to_off ? cl_mrs : dll_on_mrs);
               end
               dll_on_mrs: begin
                  issue(CMD_MRS, MR1_SEL, MR1_DLL_ON);
                  dll_off <= 1'b0;
                  hold({8'h00, t_mrd}, dll_reset_mrs);
               end
               dll_reset_mrs: begin
                  issue(CMD_MRS, MR0_SEL, mr_val[13:0] | (14'h0001 << DLL_RST_BIT));
                  lock_cnt <= t_dllk;
                  hold({8'h00, t_mrd}, cwl_mrs);
               end
               cl_mrs: begin
                  issue(CMD_MRS, MR0_SEL, MR0_CL6);
                  hold({8'h00, t_mod}, cwl_mrs);
               end
               cwl_mrs: begin
                  issue(CMD_MRS, MR2_SEL, dll_off ? MR2_CWL6 : mr_val[29:16]);
                  hold({8'h00, t_mod}, zq_en ? zq_cal : lock_wait);
               end
               zq_cal: begin
                  issue(CMD_ZQ, 3'h0, 14'h0001 << ZQ_LONG_BIT);
                  hold(t_zq, lock_wait);
               end
               lock_wait: if (lock_cnt == 16'h0000 || dll_off) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  step <= idle;
               end
               step_wait: begin
                  if (cnt <= 16'h0001) step <= ret;
                  else cnt <= cnt - 16'h0001;
               end
            endcase
         end
      end
   end
endmodule // dll_ctrl_end

// ==== core/dll_dram_end.sv ====
// dram end: mode registers, dll state, self refresh and latency report
// assumes the link is driven from logic on the same CLK
module dll_dram_end
   import dll_switch_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // link
   dll_link_if.dram LINK,
   // status
   output logic DLL_ENABLED,
   output logic DLL_LOCKED,
   output logic SELF_REFRESH,
   output logic [3:0] CAS_LAT,
   output logic [3:0] CAS_WR_LAT,
   output logic [4:0] READ_LAT,
   output logic LAT_SUPPORTED,
   output logic SPACING_ERR
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [13:0] mr0, mr1, mr2;
   logic cke_prev, seen_mrs;
   logic [9:0] lock_cnt;
   logic [7:0] gap;
   wire [3:0] cmd = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
   wire is_mrs = LINK.ck_tick && LINK.cke && cke_prev && cmd == CMD_MRS;
   wire is_sre = LINK.ck_tick && cke_prev && !LINK.cke && cmd == CMD_REF;
   wire is_srx = LINK.ck_tick && !cke_prev && LINK.cke;
   wire dll_on = !mr1[DLL_DIS_BIT];
   wire dll_rst = is_mrs && LINK.ba == MR0_SEL && LINK.addr[DLL_RST_BIT] && dll_on;
   wire [3:0] cl = {1'b0, mr0[CL_LSB+2:CL_LSB]} + CL_BASE;
   wire [3:0] cwl = {1'b0, mr2[CWL_LSB+2:CWL_LSB]} + CWL_BASE;
   wire [1:0] al_code = mr1[AL_LSB+1:AL_LSB];
   wire [4:0] al = (al_code == 2'h1) ? {1'b0, cl - 4'h1} : (al_code == 2'h2) ? {1'b0, cl - 4'h2} : 5'h00;
   // dll off launches the read strobe one edge earlier
   wire [4:0] rd_lat = al + {1'b0, cl} - {4'h0, !dll_on};
   wire lat_ok = dll_on || (cl == DLL_OFF_LAT && cwl == DLL_OFF_LAT);
   wire short_gap = is_mrs && seen_mrs && gap < 8'(T_MRD_NCK);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         mr0 <= 14'h0000;
         mr1 <= MR1_DLL_ON;
         mr2 <= 14'h0000;
         cke_prev <= 1'b0;
         seen_mrs <= 1'b0;
         gap <= 8'hFF;
         lock_cnt <= 10'h000;
         SELF_REFRESH <= 1'b0;
         DLL_LOCKED <= 1'b0;
         SPACING_ERR <= 1'b0;
      end else begin
         if (LINK.ck_tick) begin
            cke_prev <= LINK.cke;
            // edges are counted, not time, so jitter cannot shorten a gap
            gap <= is_mrs ? 8'h01 : (gap == 8'hFF ? gap : gap + 8'h01);
         end
         if (is_mrs) begin
            seen_mrs <= 1'b1;
            if (LINK.ba == MR0_SEL) mr0 <= LINK.addr;
            if (LINK.ba == MR1_SEL) mr1 <= LINK.addr;
            if (LINK.ba == MR2_SEL) mr2 <= LINK.addr;
         end
         if (short_gap) SPACING_ERR <= 1'b1;
         if (is_sre) SELF_REFRESH <= 1'b1;
         if (is_srx) SELF_REFRESH <= 1'b0;
         if (!dll_on) begin
            DLL_LOCKED <= 1'b0;
            lock_cnt <= 10'h000;
         end else if (dll_rst) begin
            DLL_LOCKED <= 1'b0;
            lock_cnt <= 10'(T_DLLK_NCK);
         end else if (LINK.ck_tick && lock_cnt != 10'h000) begin
            lock_cnt <= lock_cnt - 10'h001;
            if (lock_cnt == 10'h001) DLL_LOCKED <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         DLL_ENABLED <= 1'b1;
         CAS_LAT <= CL_BASE;
         CAS_WR_LAT <= CWL_BASE;
         READ_LAT <= 5'h00;
         LAT_SUPPORTED <= 1'b1;
      end else begin
         DLL_ENABLED <= dll_on;
         CAS_LAT <= cl;
         CAS_WR_LAT <= cwl;
         READ_LAT <= rd_lat;
         LAT_SUPPORTED <= lat_ok;
      end
   end
endmodule // dll_dram_end

// ==== core/dll_link_if.sv ====
// link between the controller end and the dram end
// assumes both ends share CLK; ck_tick marks each dram clock edge
interface dll_link_if;
   logic ck_tick;
   logic cke;
   logic odt;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [2:0] ba;
   logic [13:0] addr;
   modport ctrl (output ck_tick, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
   modport dram (input ck_tick, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// ==== core/dll_switch_pkg.sv ====
// constants shared by both ends of the dll on/off switching link
// assumes one 10 MHz clock; dram clock edges are marked by a tick enable
// ----------------------------------------------------------------
// How it works
// - idle, banks precharged, odt off before disabling
// - dll-off switch changes clock inside self refresh
// - mr1 a0 set disables dll, then wait
// - wait tcksre after self refresh entry
// - new clock stable tcksrx before exit
// - cke high from exit through every tmod
// - odt low until tmod when termination used
// - after txs reprogram modes, optional zq
// - final mode write, wait tmod, ready
// - idle with odt off before dll-on switch
// - cke high until tdllk after dll reset
// - odt low until tdllk when termination used
// - after txs clear mr1 a0, dll enabled
// - after tmrd set mr0 a8, dll resets
// - after tmrd set modes, zq after tmod
// - no locked-dll command before tdllk, tzqoper
// - spacings count real clock edges
// - nanosecond times round up to cycles
// - dll-off supports cl six, cwl six
// - dll-off read strobe one cycle earlier
// ----------------------------------------------------------------
package dll_switch_pkg;
   localparam int CLK_PERIOD_NS = 100;

   function automatic int ru_cycles(input int ns, input int per);
      int c;
      c = (ns + per - 1) / per;
      return (c < 1) ? 1 : c;
   endfunction

   // ----------------------------------------------------------------
   // timing, in dram clock edges unless named _NS
   // ----------------------------------------------------------------
   localparam int T_MRD_NCK = 4;
   localparam int T_MOD_NCK = 12;
   localparam int T_DLLK_NCK = 512;
   localparam int T_ZQOPER_NCK = 512;
   localparam int T_CKSRE_NS = 10;
   localparam int T_CKSRX_NS = 10;
   localparam int T_XS_NS = 170;
   localparam int T_CKSRE_CYC = ru_cycles(T_CKSRE_NS, CLK_PERIOD_NS);
   localparam int T_CKSRX_CYC = ru_cycles(T_CKSRX_NS, CLK_PERIOD_NS);
   localparam int T_XS_CYC = ru_cycles(T_XS_NS, CLK_PERIOD_NS);
   localparam logic [7:0] DIV_RESET = 8'h01;

   // ----------------------------------------------------------------
   // command encoding {cs_n, ras_n, cas_n, we_n} and mode fields
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_ZQ = 4'h6;
   localparam int ZQ_LONG_BIT = 10;
   localparam logic [2:0] MR0_SEL = 3'h0;
   localparam logic [2:0] MR1_SEL = 3'h1;
   localparam logic [2:0] MR2_SEL = 3'h2;
   localparam int DLL_DIS_BIT = 0;
   localparam int DLL_RST_BIT = 8;
   localparam int CL_LSB = 4;
   localparam int CWL_LSB = 3;
   localparam int AL_LSB = 3;
   localparam logic [3:0] CL_BASE = 4'h4;
   localparam logic [3:0] CWL_BASE = 4'h5;
   localparam logic [3:0] DLL_OFF_LAT = 4'h6;
   localparam logic [13:0] MR0_CL6 = 14'h0020;
   localparam logic [13:0] MR2_CWL6 = 14'h0008;
   localparam logic [13:0] MR1_DLL_ON = 14'h0000;
   localparam logic [13:0] MR1_DLL_OFF = 14'h0001;

   // ----------------------------------------------------------------
   // controller register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] TIME_A_OFS = 8'h08;
   localparam logic [7:0] TIME_B_OFS = 8'h0C;
   localparam logic [7:0] TIME_C_OFS = 8'h10;
   localparam logic [7:0] MRVAL_OFS = 8'h14;
   localparam int GO_BIT = 0;
   localparam int DIR_BIT = 1;
   localparam int ZQ_BIT = 2;
   localparam int ODT_BIT = 3;
   localparam int BUSY_BIT = 0;
   localparam int DONE_BIT = 1;
   localparam int DLLOFF_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verif/dll_link_monitor.sv ====
// checker for the dram link: mode write spacing, cke, odt and command timing
// assumes every link signal is a flop on CLK, sampled where ck_tick is high
module dll_link_monitor
   import dll_switch_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // link
   input wire logic ck_tick,
   input wire logic cke,
   input wire logic odt,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [13:0] addr
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic [3:0] cmd;
   logic mrs;
   logic sre;
   logic [7:0] since_mrs;
   logic [8:0] gap;
   logic tick_cke;
   logic [2:0] last_ba;
   logic last_a0;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign mrs = ck_tick && cmd == CMD_MRS;
   assign sre = ck_tick && cmd == CMD_REF && !cke;
   // saturates so a long quiet spell never wraps into a false short gap
   always_ff @(posedge CLK) begin
      if (RESET) begin
         since_mrs <= 8'hFF;
         tick_cke <= 1'b1;
         last_ba <= 3'h0;
         last_a0 <= 1'b0;
      end else if (ck_tick) begin
         since_mrs <= mrs ? 8'h01 : (since_mrs == 8'hFF ? since_mrs : since_mrs + 8'h01);
         tick_cke <= cke;
         last_ba <= mrs ? ba : last_ba;
         last_a0 <= mrs ? addr[0] : last_a0;
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET || ck_tick) begin
         gap <= 9'h000;
      end else begin
         gap <= gap + 9'h001;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   chk_mrs_spacing: assert property (mrs |-> since_mrs >= 8'(T_MRD_NCK))
      else $error("mode writes closer than four ticks");
   chk_sre_after_mod: assert property (sre |-> since_mrs >= 8'(T_MOD_NCK))
      else $error("self refresh entered before tmod");
   chk_cke_fall_sre: assert property ($fell(cke) |-> cmd == CMD_REF)
      else $error("cke fell without self refresh entry");
   chk_srx_is_nop: assert property ($rose(cke) |-> cmd == CMD_NOP && $past(cmd, 1) != CMD_MRS)
      else $error("self refresh exit without nop");
   chk_mrs_cke_high: assert property (mrs |-> cke && tick_cke)
      else $error("mode write without cke held high");
   chk_odt_low: assert property ((!cke || mrs) |-> !odt)
      else $error("odt high during switch");
   chk_cmd_hold: assert property ($changed({cmd, ba, addr}) |-> $past(ck_tick))
      else $error("command changed off a tick");
   chk_dll_reset_order: assert property (mrs && ba == MR0_SEL && addr[DLL_RST_BIT] |->
      last_ba == MR1_SEL && !last_a0)
      else $error("dll reset not preceded by dll enable");
   chk_tick_alive: assert property (gap < 9'h100)
      else $error("dram clock stopped");
   cov_sre: cover property (sre);
   cov_srx: cover property ($rose(cke));
   cov_dll_reset: cover property (mrs && ba == MR0_SEL && addr[DLL_RST_BIT]);
endmodule // dll_link_monitor

// ==== verif/testbench.sv ====
// self-checking bench: both link ends, axi4-lite master tasks, checker
// assumes a 10 MHz clock and synchronous active-high reset
module testbench
   import dll_switch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rd_r, wr_r;
   logic dll_enabled, dll_locked, self_refresh, lat_supported, spacing_err;
   logic [3:0] cas_lat, cas_wr_lat;
   logic [4:0] read_lat;
   int errors = 0;
   int total_checks = 0;
   row_t rows[6] = '{'{STATUS_OFS, 32'h00000100, RESP_OKAY}, '{TIME_A_OFS, 32'h0101040C, RESP_OKAY},
      '{TIME_B_OFS, 32'h02000002, RESP_OKAY}, '{TIME_C_OFS, 32'h00000200, RESP_OKAY},
      '{MRVAL_OFS, 32'h00080020, RESP_OKAY}, '{8'h18, 32'h00000000, RESP_SLVERR}};
   always #50 clk = ~clk;

   // ----------------------------------------------------------------
   // both ends and the checker
   // ----------------------------------------------------------------
   dll_link_if link();
   dll_ctrl_end dll_ctrl_end_i (.CLK(clk), .RESET(rst), .LINK(link), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   dll_dram_end dll_dram_end_i (.CLK(clk), .RESET(rst), .LINK(link), .DLL_ENABLED(dll_enabled),
      .DLL_LOCKED(dll_locked), .SELF_REFRESH(self_refresh), .CAS_LAT(cas_lat), .CAS_WR_LAT(cas_wr_lat),
      .READ_LAT(read_lat), .LAT_SUPPORTED(lat_supported), .SPACING_ERR(spacing_err));
   dll_link_monitor dll_link_monitor_i (.CLK(clk), .RESET(rst), .ck_tick(link.ck_tick), .cke(link.cke),
      .odt(link.odt), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
      .ba(link.ba), .addr(link.addr));

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wr_r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_d = rdata;
      rd_r = rresp;
      rready <= 1'b0;
   endtask
   // polls status; a stuck sequencer is left to the watchdog
   task automatic wait_done();
      do axi_rd(STATUS_OFS); while (rd_d[DONE_BIT] !== 1'b1);
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         axi_rd(rows[i].a);
         `CHK(rd_d, rows[i].d)
         `CHK(rd_r, rows[i].r)
      end
      // lock time stays at the dram's own; only the exit wait is stretched
      axi_wr(TIME_B_OFS, 32'h02000003, 4'hF);
      `CHK(wr_r, RESP_OKAY)
      axi_wr(TIME_C_OFS, 32'hFFFF0008, 4'h3);
      axi_rd(TIME_C_OFS);
      `CHK(rd_d, 32'h00000008)
      axi_wr(8'h1C, 32'h00000001, 4'hF);
      `CHK(wr_r, RESP_SLVERR)
      // to dll off at half rate, with long calibration
      axi_wr(CTRL_OFS, 32'h00000207, 4'hF);
      axi_rd(STATUS_OFS);
      `CHK(rd_d[BUSY_BIT], 1'b1)
      axi_wr(TIME_A_OFS, 32'hFFFFFFFF, 4'hF);
      axi_rd(TIME_A_OFS);
      `CHK(rd_d, 32'h0101040C)
      wait_done();
      `CHK(rd_d, 32'h00000206)
      `CHK(dll_enabled, 1'b0)
      `CHK(self_refresh, 1'b0)
      `CHK(cas_lat, DLL_OFF_LAT)
      `CHK(cas_wr_lat, DLL_OFF_LAT)
      `CHK(lat_supported, 1'b1)
      `CHK(read_lat, 5'h05)
      `CHK(spacing_err, 1'b0)
      // back to dll on at full rate, termination allowed when idle
      axi_wr(CTRL_OFS, 32'h00000109, 4'hF);
      wait_done();
      `CHK(rd_d, 32'h00000102)
      `CHK(dll_enabled, 1'b1)
      `CHK(dll_locked, 1'b1)
      `CHK(read_lat, 5'h06)
      `CHK(spacing_err, 1'b0)
      // div of zero and a go without byte lane zero are both ignored
      axi_wr(CTRL_OFS, 32'h00000008, 4'hF);
      axi_wr(CTRL_OFS, 32'h00000003, 4'hE);
      axi_rd(CTRL_OFS);
      `CHK(rd_d, 32'h00000108)
      axi_rd(STATUS_OFS);
      `CHK(rd_d, 32'h00000102)
      // reset while idle after both switches brings both ends back
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(dll_enabled, 1'b1)
      `CHK(dll_locked, 1'b0)
      `CHK(cas_lat, CL_BASE)
      axi_rd(STATUS_OFS);
      `CHK(rd_d, 32'h00000100)
      tally_and_finish();
   end
   // the two switches with short waits need a few thousand cycles at most
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
endmodule // testbench
